/* File: rtl/ielr_regs.sv */
`timescale 1ns/1ps
module ielr_regs
   import ielr_pkg::*;
#(
   parameter logic [1:0] DEV_VERSION = 2'h0 // Arbitrary version value
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic init_req,
   input wire logic [DATA_W-1:0] init_acd,
   input wire logic [2:0] init_bus_id,
   input wire logic ic_req,
   input wire logic ic_wr,
   input wire logic [ADDR_W-1:0] ic_addr,
   input wire logic [DATA_W-1:0] ic_wdata,
   output logic ic_ack,
   output logic [DATA_W-1:0] ic_rdata,
   input wire logic pl_req,
   input wire logic pl_wr,
   input wire logic [1:0] pl_addr,
   input wire logic [DATA_W-1:0] pl_wdata,
   output logic pl_ack,
   output logic [DATA_W-1:0] pl_rdata,
   input wire logic rpt_valid,
   input wire logic [5:0] rpt_module_id,
   input wire logic [2:0] rpt_bus_id,
   input wire ielr_err_type rpt_type,
   input wire logic rpt_permanent,
   output logic cmd_fault_test,
   output logic cmd_report_test,
   output logic cmd_bus_swap,
   output logic cmd_disconnect,
   output logic cmd_connect,
   output logic [1:0] report_count
);

   typedef struct packed {
      logic [5:0] log_mod;
      logic [2:0] log_bus;
      logic [3:0] log_type;
      logic log_perm;
      logic [1:0] log_cnt;
      logic [DATA_W-1:0] dev_type;
      logic [DATA_W-1:0] dev_id;
      logic p1_valid;
      logic p1_is_pl;
      logic [ADDR_W-1:0] p1_addr;
      logic ic_ack;
      logic [DATA_W-1:0] ic_rdata;
      logic pl_ack;
      logic [DATA_W-1:0] pl_rdata;
      logic cmd_fault_test;
      logic cmd_report_test;
      logic cmd_bus_swap;
      logic cmd_disconnect;
      logic cmd_connect;
   } ielr_state_type;

   ielr_state_type st_r;
   ielr_state_type st_nxt;

   ielr_mem_if mem ();

   ielr_reg_mem u_mem (
      .clk(clk),
      .arst_n(arst_n),
      .mem(mem.store)
   );

   ////////////////////////////////////////////////////////////////////////
   // Offsets backed by the storage array
   function automatic logic is_stored(input logic [ADDR_W-1:0] a);
      begin
         is_stored = (a >= OFS_LOGICAL_IDENTIFIER && a <= OFS_INTERLEAVE) ||
            (a == OFS_ACTIVITY);
      end
   endfunction : is_stored

   function automatic logic is_cmd(input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] ofs);
      begin
         is_cmd = (a == ofs);
      end
   endfunction : is_cmd

   // One word view of the log, so every read sees a single snapshot
   function automatic logic [DATA_W-1:0] log_word(input ielr_state_type s);
      logic [DATA_W-1:0] w;
      begin
         w = '0;
         w[LOG_MOD_LSB +: 6] = s.log_mod;
         w[LOG_BUS_LSB +: 3] = s.log_bus;
         w[LOG_TYPE_LSB +: 4] = s.log_type;
         w[LOG_PERM_BIT] = s.log_perm;
         w[LOG_CNT_LSB +: 2] = s.log_cnt;
         log_word = w;
      end
   endfunction : log_word

   ////////////////////////////////////////////////////////////////////////
   // Port selection: interconnect access wins, local access is not taken while ic_req is high
   logic take_ic;
   logic take_pl;
   logic acc_wr;
   logic [ADDR_W-1:0] acc_addr;
   logic [DATA_W-1:0] acc_wdata;
   logic [ADDR_W-1:0] pl_ofs;
   logic [DATA_W-1:0] rd_word;

   always_comb
   begin
      take_ic = ic_req;
      take_pl = pl_req && !ic_req;
      pl_ofs = (pl_addr == PL_IPC_MSG) ? OFS_IPC_MSG : OFS_PROC_ID;
      acc_addr = take_ic ? ic_addr : pl_ofs;
      acc_wr = take_ic ? ic_wr : (take_pl && pl_wr);
      acc_wdata = take_ic ? ic_wdata : pl_wdata;
   end

   // Writes land only in storage locations; all else is dropped
   assign mem.we = (take_ic || take_pl) && acc_wr && is_stored(acc_addr);
   assign mem.addr = acc_addr;
   assign mem.wdata = acc_wdata;

   ////////////////////////////////////////////////////////////////////////
   // Read data for the access taken one cycle earlier
   always_comb
   begin
      rd_word = '0;
      if (is_stored(st_r.p1_addr))
      begin
         rd_word = mem.rdata;
      end
      else if (st_r.p1_addr == OFS_ERR_LOG)
      begin
         rd_word = log_word(st_r);
      end
      else if (st_r.p1_addr == OFS_DEV_TYPE)
      begin
         rd_word = st_r.dev_type;
      end
      else if (st_r.p1_addr == OFS_DEV_ID)
      begin
         rd_word = st_r.dev_id;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic swap_now;
      logic clr_cnt;
      swap_now = take_ic && is_cmd(ic_addr, OFS_BUS_SWAP_CMD);
      clr_cnt = init_req || swap_now;
      st_nxt = st_r;

      // Access pipeline
      st_nxt.p1_valid = take_ic || take_pl;
      st_nxt.p1_is_pl = take_pl;
      st_nxt.p1_addr = acc_addr;
      st_nxt.ic_ack = st_r.p1_valid && !st_r.p1_is_pl;
      st_nxt.pl_ack = st_r.p1_valid && st_r.p1_is_pl;
      if (st_r.p1_valid && !st_r.p1_is_pl)
      begin
         st_nxt.ic_rdata = rd_word;
      end
      if (st_r.p1_valid && st_r.p1_is_pl)
      begin
         st_nxt.pl_rdata = rd_word;
      end

      // Command pulses on any access, read or write
      st_nxt.cmd_fault_test = take_ic && is_cmd(ic_addr, OFS_FAULT_CMD);
      st_nxt.cmd_report_test = take_ic &&
         is_cmd(ic_addr, OFS_RPT_TEST_CMD);
      st_nxt.cmd_bus_swap = swap_now;
      st_nxt.cmd_disconnect = take_ic && is_cmd(ic_addr, OFS_DISCONN_CMD);
      st_nxt.cmd_connect = take_ic && is_cmd(ic_addr, OFS_CONNECT_CMD);

      // Initialization: keep crash evidence, clear count and flag
      if (init_req)
      begin
         st_nxt.log_perm = 1'b0;
         st_nxt.dev_type = '0;
         st_nxt.dev_type[DT_BB_LSB +: 2] = init_acd[ACD_BB_LSB +: 2];
         st_nxt.dev_type[DT_PPP_LSB +: 3] = init_acd[ACD_PPP_LSB +: 3];
         st_nxt.dev_type[DT_VV_LSB +: 2] = DEV_VERSION;
         st_nxt.dev_type[DT_F_BIT] = 1'b1;
         st_nxt.dev_type[DT_DDD_LSB +: 3] = DT_DDD;
         st_nxt.dev_id = '0;
         st_nxt.dev_id[5:0] = init_acd[ACD_MOD_LSB +: 6];
         st_nxt.dev_id[DID_BUS_LSB +: 3] = init_bus_id;
      end
      if (clr_cnt)
      begin
         st_nxt.log_cnt = '0;
      end

      // Report logging; a report in a clearing cycle still counts
      if (rpt_valid)
      begin
         st_nxt.log_mod = rpt_module_id;
         st_nxt.log_bus = rpt_bus_id;
         st_nxt.log_type = rpt_type;
         st_nxt.log_perm = rpt_permanent;
         if (clr_cnt)
         begin
            st_nxt.log_cnt = CNT_ONE;
         end
         else if (st_r.log_cnt != CNT_MAX)
         begin
            st_nxt.log_cnt = st_r.log_cnt + CNT_ONE;
         end
         else
         begin
            st_nxt.log_cnt = CNT_MAX;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign ic_ack = st_r.ic_ack;
   assign ic_rdata = st_r.ic_rdata;
   assign pl_ack = st_r.pl_ack;
   assign pl_rdata = st_r.pl_rdata;
   assign cmd_fault_test = st_r.cmd_fault_test;
   assign cmd_report_test = st_r.cmd_report_test;
   assign cmd_bus_swap = st_r.cmd_bus_swap;
   assign cmd_disconnect = st_r.cmd_disconnect;
   assign cmd_connect = st_r.cmd_connect;
   assign report_count = st_r.log_cnt;

endmodule : ielr_regs

/* File: inc/ielr_pkg.sv */
package ielr_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int MEM_DEPTH = 32;

   // Interconnect register offsets (one 16-bit location each)
   localparam logic [4:0] OFS_ERR_LOG = 5'h00;
   localparam logic [4:0] OFS_DEV_TYPE = 5'h01;
   localparam logic [4:0] OFS_DEV_ID = 5'h02;
   localparam logic [4:0] OFS_LOGICAL_IDENTIFIER = 5'h04;
   localparam logic [4:0] OFS_PARTNER_ID = 5'h05;
   localparam logic [4:0] OFS_UNIT_STATE = 5'h06;
   localparam logic [4:0] OFS_DIAG_CTRL = 5'h07;
   localparam logic [4:0] OFS_TIMEOUT_LEN = 5'h08;
   localparam logic [4:0] OFS_MEM_BOUNDS = 5'h09;
   localparam logic [4:0] OFS_PROC_ID = 5'h0A;
   localparam logic [4:0] OFS_FAULT_DATA = 5'h0B;
   localparam logic [4:0] OFS_IPC_MSG = 5'h0C;
   localparam logic [4:0] OFS_INTERLEAVE = 5'h0D;
   localparam logic [4:0] OFS_ACTIVITY = 5'h1A;
   localparam logic [4:0] OFS_FAULT_CMD = 5'h1B;
   localparam logic [4:0] OFS_RPT_TEST_CMD = 5'h1C;
   localparam logic [4:0] OFS_BUS_SWAP_CMD = 5'h1D;
   localparam logic [4:0] OFS_DISCONN_CMD = 5'h1E;
   localparam logic [4:0] OFS_CONNECT_CMD = 5'h1F;

   // Processor-local byte addresses
   localparam logic [1:0] PL_PROC_ID = 2'h0;
   localparam logic [1:0] PL_IPC_MSG = 2'h2;

   // Error log field layout
   localparam int LOG_MOD_LSB = 10;
   localparam int LOG_BUS_LSB = 7;
   localparam int LOG_TYPE_LSB = 3;
   localparam int LOG_PERM_BIT = 2;
   localparam int LOG_CNT_LSB = 0;
   localparam logic [1:0] CNT_MAX = 2'h3;
   localparam logic [1:0] CNT_ONE = 2'h1;

   // Device type field layout and fixed values
   localparam int DT_BB_LSB = 11;
   localparam int DT_PPP_LSB = 8;
   localparam int DT_VV_LSB = 4;
   localparam int DT_F_BIT = 3;
   localparam int DT_DDD_LSB = 0;
   localparam logic [2:0] DT_DDD = 3'h1;
   localparam int ACD_PPP_LSB = 3;
   localparam int ACD_BB_LSB = 6;
   localparam int ACD_MOD_LSB = 8;
   localparam int DID_BUS_LSB = 6;

   typedef enum logic [3:0] {
      ET_TOGGLE = 4'h0,
      ET_DETACH = 4'h1,
      ET_ATTACH = 4'h2,
      ET_INTERCHANGE = 4'h3,
      ET_TEST_REPORT = 4'h4,
      ET_CORR_ECC = 4'h5,
      ET_UNCORR_ECC = 4'h6,
      ET_BUS_MOD_LOW = 4'h7,
      ET_BUS_PARITY = 4'h8,
      ET_MODULE = 4'h9,
      ET_NO_ERROR = 4'hA,
      ET_BUS_MOD_HIGH = 4'hB,
      ET_BUS_ARB = 4'hC,
      ET_UNSAFE_MOD = 4'hD,
      ET_MEL_PARITY = 4'hE,
      ET_BEL_PARITY = 4'hF
   } ielr_err_type;

endpackage : ielr_pkg

/* File: inc/ielr_mem_if.sv */
`timescale 1ns/1ps
interface ielr_mem_if;
   import ielr_pkg::*;
   logic we;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport store (input we, input addr, input wdata, output rdata);
endinterface : ielr_mem_if

/* File: rtl/ielr_reg_mem.sv */
`timescale 1ns/1ps
module ielr_reg_mem
   import ielr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   ielr_mem_if.store mem
);

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
   } ielr_mem_st_type;

   logic [DATA_W-1:0] store_r [MEM_DEPTH];
   ielr_mem_st_type st_r;
   ielr_mem_st_type st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Array itself is not reset: it models plain storage cells
   always_ff @(posedge clk)
   begin
      if (mem.we)
      begin
         store_r[mem.addr] <= mem.wdata;
      end
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdata = store_r[mem.addr];
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign mem.rdata = st_r.rdata;

endmodule : ielr_reg_mem

/* File: verification/ielr_chk_assertions.sv */
`timescale 1ns/1ps
module ielr_chk
   import ielr_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic init_req,
   input wire logic ic_req,
   input wire logic ic_wr,
   input wire logic [ADDR_W-1:0] ic_addr,
   input wire logic ic_ack,
   input wire logic [DATA_W-1:0] ic_rdata,
   input wire logic pl_req,
   input wire logic pl_ack,
   input wire logic rpt_valid,
   input wire logic [5:0] rpt_module_id,
   input wire logic [2:0] rpt_bus_id,
   input wire logic cmd_bus_swap,
   input wire logic cmd_connect,
   input wire logic [1:0] report_count
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic swp;
   logic hold;
   assign swp = ic_req && ic_addr == OFS_BUS_SWAP_CMD;
   // Clear beside a report lets the report win, so excluded here
   assign hold = rpt_valid && !init_req && !swp;
   ////////////////////////////////////////
   sequence s_rpt;
      rpt_valid ##1 (ic_req && !ic_wr && ic_addr == OFS_ERR_LOG && !rpt_valid)
         ##1 !rpt_valid;
   endsequence
   property p_ack; ic_req |-> ##2 ic_ack; endproperty
   a_ack: assert property (p_ack) else $error("ic ack late");
   property p_pl; pl_req && !ic_req |-> ##2 pl_ack; endproperty
   a_pl: assert property (p_pl) else $error("pl ack late");
   property p_rsv;
      ic_req && !ic_wr && ic_addr == 5'h03 |-> ##2 ic_rdata == 16'h0000;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved not zero");
   property p_cmd; ic_req && ic_addr == OFS_CONNECT_CMD |=> cmd_connect;
   endproperty
   a_cmd: assert property (p_cmd) else $error("no connect pulse");
   property p_nocmd; !swp |=> !cmd_bus_swap; endproperty
   a_nocmd: assert property (p_nocmd) else $error("stray swap");
   property p_inc;
      hold && report_count != CNT_MAX |=>
         report_count == $past(report_count) + CNT_ONE;
   endproperty
   a_inc: assert property (p_inc) else $error("count step");
   property p_sat; hold && report_count == CNT_MAX |=> report_count == CNT_MAX;
   endproperty
   a_sat: assert property (p_sat) else $error("count wrap");
   property p_clr; (init_req || swp) && !rpt_valid |=> report_count == 2'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("count kept");
   property p_log;
      s_rpt |-> ##1
         ic_rdata[15:7] == {$past(rpt_module_id, 3), $past(rpt_bus_id, 3)};
   endproperty
   a_log: assert property (p_log) else $error("log source");
endmodule : ielr_chk
bind ielr_regs ielr_chk chk_u (.*);

/* File: verification/ielr_rpt_src.sv */
`timescale 1ns/1ps
module ielr_rpt_src
   import ielr_pkg::*;
(
   input wire logic clk,
   output logic rpt_valid,
   output logic [5:0] rpt_module_id,
   output logic [2:0] rpt_bus_id,
   output ielr_err_type rpt_type,
   output logic rpt_permanent
);
   logic [13:0] f_r = 14'h0;
   initial rpt_valid = 1'b0;
   assign {rpt_module_id, rpt_bus_id} = f_r[13:5];
   assign rpt_type = ielr_err_type'(f_r[4:1]);
   assign rpt_permanent = f_r[0];
   // Called at a falling edge; fields hold one cycle only
   task automatic send(input logic [13:0] f);
      rpt_valid = 1'b1;
      f_r = f;
      @(negedge clk);
      rpt_valid = 1'b0;
      // Stale fields inverted so a late sample cannot match
      f_r = ~f;
   endtask : send
endmodule : ielr_rpt_src

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import ielr_pkg::*;
   localparam logic [1:0] VER = 2'h2; // Arbitrary value
   logic clk, arst_n, init_req, ic_req, ic_wr, ic_ack, pl_req, pl_wr, p;
   logic pl_ack, rpt_valid, rpt_permanent, cmd_fault_test, cmd_connect;
   logic cmd_report_test, cmd_bus_swap, cmd_disconnect;
   logic [15:0] init_acd, ic_wdata, ic_rdata, pl_wdata, pl_rdata, d;
   logic [4:0] ic_addr, cmds;
   logic [2:0] init_bus_id, rpt_bus_id, b;
   logic [1:0] pl_addr, report_count;
   logic [5:0] rpt_module_id, m;
   ielr_err_type rpt_type;
   logic [15:0] qi[$], qp[$];
   // Writes are answered too; these notes tell the monitor to skip them
   bit wi[$], wp[$];
   int seed, error_cnt, total_checks;
   assign cmds = {cmd_connect, cmd_disconnect, cmd_bus_swap,
      cmd_report_test, cmd_fault_test};
   ielr_regs #(.DEV_VERSION(VER)) dut_u (.*);
   ielr_rpt_src rpt_u (.*);
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // Request left high so calls run back to back
   task automatic ic(input logic w, input logic [4:0] a,
      input logic [15:0] dw, input logic [15:0] e);
      {ic_req, ic_wr, ic_addr, ic_wdata} = {1'b1, w, a, dw};
      wi.push_back(w);
      if (!w)
         qi.push_back(e);
      @(negedge clk);
   endtask : ic
   task automatic pl(input logic w, input logic [1:0] a,
      input logic [15:0] dw, input logic [15:0] e);
      {pl_req, pl_wr, pl_addr, pl_wdata} = {1'b1, w, a, dw};
      wp.push_back(w);
      if (!w)
         qp.push_back(e);
      @(negedge clk);
   endtask : pl
   always @(negedge clk)
   begin
      if (ic_ack === 1'b1)
         if (!wi.pop_front())
            chk(ic_rdata, qi.pop_front());
      if (pl_ack === 1'b1)
         if (!wp.pop_front())
            chk(pl_rdata, qp.pop_front());
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      chk(16'h0, 16'h1);
      end_sim();
   end
   initial
   begin
      seed = 32'h4B6F;
      {init_req, ic_req, ic_wr, pl_req, pl_wr, ic_addr, pl_addr} = '0;
      {ic_wdata, pl_wdata, init_acd, init_bus_id} = '0;
      arst_n = 1'b0;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      for (int i = 3; i < 27; i++)
      begin
         d = 16'($random(seed));
         // Reserved locations only ever get their own zero value back
         ic(1'b1, i[4:0], ((i > 3 && i < 14) || i == 26) ? d : 16'h0,
            16'h0);
         ic(1'b0, i[4:0], 16'h0, ((i > 3 && i < 14) || i == 26) ? d : 16'h0);
      end
      // Read-only log must ignore the write
      ic(1'b1, OFS_ERR_LOG, d, 16'h0);
      ic(1'b0, OFS_ERR_LOG, 16'h0, 16'h0);
      ic_req = 1'b0;
      $display("regs done");
      for (int i = 0; i < 16; i++)
      begin
         {m, b, p} = 10'($random(seed));
         rpt_u.send({m, b, i[3:0], p});
         ic(1'b0, OFS_ERR_LOG, 16'h0,
            {m, b, i[3:0], p, (i < 3) ? i[1:0] + 2'h1 : CNT_MAX});
         ic_req = 1'b0;
         @(negedge clk);
      end
      $display("reports done");
      for (int i = 27; i < 32; i++)
      begin
         ic(1'b0, i[4:0], 16'h0, 16'h0);
         chk({11'h0, cmds}, 16'h1 << (i - 27));
      end
      ic(1'b0, OFS_ERR_LOG, 16'h0, {m, b, 4'hF, p, 2'h0});
      ic_req = 1'b0;
      $display("commands done");
      rpt_u.send({m, b, 4'h5, 1'b1});
      {init_acd, init_bus_id} = 19'($random(seed));
      init_req = 1'b1;
      @(negedge clk);
      init_req = 1'b0;
      ic(1'b0, OFS_ERR_LOG, 16'h0, {m, b, 4'h5, 3'h0});
      ic(1'b0, OFS_DEV_TYPE, 16'h0,
         {3'h0, init_acd[7:3], 2'h0, VER, 1'b1, DT_DDD});
      ic(1'b0, OFS_DEV_ID, 16'h0,
         {7'h0, init_bus_id, init_acd[13:8]});
      ic_req = 1'b0;
      $display("init done");
      pl(1'b1, PL_PROC_ID, d, 16'h0);
      pl(1'b1, PL_IPC_MSG, ~d, 16'h0);
      pl_req = 1'b0;
      ic(1'b0, OFS_PROC_ID, 16'h0, d);
      ic(1'b0, OFS_IPC_MSG, 16'h0, ~d);
      ic(1'b1, OFS_PROC_ID, ~d, 16'h0);
      ic_req = 1'b0;
      pl(1'b0, PL_PROC_ID, 16'h0, ~d);
      pl(1'b0, PL_IPC_MSG, 16'h0, ~d);
      pl_req = 1'b0;
      for (int i = 0; i < 20 && qi.size() + qp.size() > 0; i++)
         @(negedge clk);
      chk(16'(qi.size() + qp.size()), 16'h0);
      $display("local done");
      end_sim();
   end
endmodule : testbench
